// ==== core/tmr_core.sv ====
// modulo timer core: prescaler, counter, modulo, readout latch and register port
//
// The implementer's own choice: the strobed register port.
`default_nettype none

module tmr_core (
  input wire logic clk,
  input wire logic nrst,
  input wire logic clkEn,
  input wire logic [tmr_pkg::ADDR_W-1:0] addr,
  input wire logic [tmr_pkg::DATA_W-1:0] wrData,
  input wire logic wrStb,
  input wire logic rdStb,
  output logic [tmr_pkg::DATA_W-1:0] rdData,
  input wire logic extClockPin,
  input wire logic portDirBit,
  input wire logic breakActive,
  input wire logic stopMode,
  input wire logic [1:0] chanEvent,
  output logic extPinDriveOk,
  output logic overflowIrq,
  output logic overflowTick,
  output logic [tmr_pkg::CNT_W-1:0] counterValue,
  output logic [tmr_pkg::DATA_W-1:0] chan0Ctrl,
  output logic [tmr_pkg::DATA_W-1:0] chan1Ctrl
);
  import tmr_pkg::*;

  // two-step clear: a new event always wins over the zero-write
  function automatic logic flagNext(input logic flag, input logic armed,
                                    input logic setEv, input logic zeroWr);
    flagNext = setEv | (flag & ~(armed & zeroWr));
  endfunction

  // the clear is armed by a read seeing the flag, cancelled by an event or any write
  function automatic logic armNext(input logic flag, input logic armed, input logic setEv,
                                   input logic rdHit, input logic wrHit);
    if (setEv) begin
      armNext = 1'b0;
    end else if (wrHit) begin
      armNext = 1'b0;
    end else if (rdHit && flag) begin
      armNext = 1'b1;
    end else begin
      armNext = armed;
    end
  endfunction

  function automatic logic divTick(input logic [SEL_W-1:0] sel, input logic [PRE_W-1:0] pre);
    logic [PRE_W-1:0] mask;
    mask = PRE_W'((8'h01 << sel) - 8'h01);
    divTick = (pre & mask) == mask;
  endfunction

  logic clockSel_q;
  logic [SEL_W-1:0] sel_q;
  logic halt_q;
  logic irqEn_q;
  logic ovfFlag_q;
  logic ovfArmed_q;
  logic [CNT_W-1:0] count_q;
  logic [PRE_W-1:0] pre_q;
  logic [CNT_W-1:0] mod_q;
  logic modPending_q;
  logic [DATA_W-1:0] lowBuf_q;
  logic latched_q;
  logic [DATA_W-1:0] ch0_q;
  logic [DATA_W-1:0] ch1_q;
  logic [1:0] chFlag_q;
  logic [1:0] chArmed_q;
  logic [DATA_W-1:0] rdData_q;
  logic irq_q;
  logic ovfTick_q;
  logic drive_q;
  logic extRise;

  tmr_ext_sync u_ext_sync (
    .clk(clk),
    .nrst(nrst),
    .clkEn(clkEn),
    .pinIn(extClockPin),
    .riseTick(extRise)
  );

  logic wrStatus;
  logic rdStatus;
  logic cntRstWr;
  logic running;
  logic tick;
  logic atModulo;
  logic ovfEvent;
  logic [1:0] chWr;
  logic [1:0] chRd;

  assign wrStatus = wrStb && (addr == OFS_STATUS);
  assign rdStatus = rdStb && (addr == OFS_STATUS);
  assign cntRstWr = wrStatus && wrData[BIT_CNT_RST];
  assign chWr = {wrStb && (addr == OFS_CH1), wrStb && (addr == OFS_CH0)};
  assign chRd = {rdStb && (addr == OFS_CH1), rdStb && (addr == OFS_CH0)};

  // break and stop state both freeze counting; wait state does not reach here
  assign running = !halt_q && !breakActive && !stopMode;
  assign tick = (sel_q == SEL_EXT) ? extRise : divTick(sel_q, pre_q);
  assign atModulo = (count_q == mod_q);
  assign ovfEvent = running && tick && atModulo && !cntRstWr && !modPending_q;

  // control fields of the status register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sel_q <= SEL_RST;
      halt_q <= HALT_RST;
      irqEn_q <= 1'b0;
    end else if (clkEn && wrStatus) begin
      sel_q <= wrData[BIT_SEL_LO +: SEL_W];
      halt_q <= wrData[BIT_HALT];
      irqEn_q <= wrData[BIT_IRQ_EN];
    end
  end

  // clockSel_q is kept as a plain marker of the external source; nothing reads it, the port logic uses sel_q
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      clockSel_q <= 1'b0;
    end else if (clkEn) begin
      clockSel_q <= (sel_q == SEL_EXT);
    end
  end

  // prescaler only advances while counting, so a halt keeps the phase
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pre_q <= PRE_RST;
    end else if (clkEn) begin
      if (cntRstWr) begin
        pre_q <= PRE_RST;
      end else if (running) begin
        pre_q <= pre_q + 7'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count_q <= CNT_RST;
    end else if (clkEn) begin
      if (cntRstWr) begin
        count_q <= CNT_RST;
      end else if (running && tick) begin
        if (atModulo) begin
          count_q <= CNT_RST;
        end else begin
          count_q <= count_q + 16'h0001;
        end
      end
    end
  end

  // overflow flag with its two-step clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ovfFlag_q <= 1'b0;
      ovfArmed_q <= 1'b0;
    end else if (clkEn) begin
      ovfFlag_q <= flagNext(ovfFlag_q, ovfArmed_q, ovfEvent,
                            wrStatus && !wrData[BIT_FLAG]);
      ovfArmed_q <= armNext(ovfFlag_q, ovfArmed_q, ovfEvent, rdStatus, wrStatus);
    end
  end

  // modulo bytes; a pending high byte mutes overflows until the low byte lands
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mod_q <= MOD_RST;
      modPending_q <= 1'b0;
    end else if (clkEn && wrStb) begin
      if (addr == OFS_MOD_HI) begin
        mod_q[CNT_W-1:DATA_W] <= wrData;
        modPending_q <= 1'b1;
      end else if (addr == OFS_MOD_LO) begin
        mod_q[DATA_W-1:0] <= wrData;
        modPending_q <= 1'b0;
      end
    end
  end

  // low-byte holding buffer; counter reset drops it so both bytes read zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lowBuf_q <= CNT_RST[DATA_W-1:0];
      latched_q <= 1'b0;
    end else if (clkEn) begin
      if (cntRstWr) begin
        lowBuf_q <= CNT_RST[DATA_W-1:0];
        latched_q <= 1'b0;
      end else if (rdStb && addr == OFS_CNT_HI && !latched_q) begin
        lowBuf_q <= count_q[DATA_W-1:0];
        latched_q <= 1'b1;
      end else if (rdStb && addr == OFS_CNT_LO) begin
        latched_q <= 1'b0;
      end
    end
  end

  // channel control bytes; their function lives in the channel logic
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ch0_q <= CH_RST;
      ch1_q <= CH_RST;
    end else if (clkEn) begin
      if (chWr[0]) begin
        ch0_q <= wrData;
      end
      if (chWr[1]) begin
        ch1_q <= wrData & CH1_WR_MASK;
      end
    end
  end

  // channel event flags share the overflow flag's clear discipline
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      chFlag_q <= 2'h0;
      chArmed_q <= 2'h0;
    end else if (clkEn) begin
      for (int i = 0; i < 2; i++) begin
        chFlag_q[i] <= flagNext(chFlag_q[i], chArmed_q[i], chanEvent[i],
                                chWr[i] && !wrData[BIT_CH_FLAG]);
        chArmed_q[i] <= armNext(chFlag_q[i], chArmed_q[i], chanEvent[i], chRd[i], chWr[i]);
      end
    end
  end

  // read data stand for exactly one cycle; unmapped reads answer zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdData_q <= RD_IDLE;
    end else if (clkEn) begin
      rdData_q <= RD_IDLE;
      if (rdStb) begin
        case (addr)
          OFS_STATUS: rdData_q <= {ovfFlag_q, irqEn_q, halt_q, 2'b00, sel_q};
          OFS_CNT_HI: rdData_q <= count_q[CNT_W-1:DATA_W];
          OFS_CNT_LO: rdData_q <= latched_q ? lowBuf_q : count_q[DATA_W-1:0];
          OFS_MOD_HI: rdData_q <= mod_q[CNT_W-1:DATA_W];
          OFS_MOD_LO: rdData_q <= mod_q[DATA_W-1:0];
          OFS_CH0: rdData_q <= {chFlag_q[0], ch0_q[6:0]};
          OFS_CH1: rdData_q <= {chFlag_q[1], ch1_q[6:0]};
          default: rdData_q <= RD_IDLE;
        endcase
      end
    end
  end

  // outputs, all registered
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_q <= 1'b0;
      ovfTick_q <= 1'b0;
      drive_q <= 1'b0;
    end else if (clkEn) begin
      irq_q <= ovfFlag_q && irqEn_q;
      ovfTick_q <= ovfEvent;
      // pin may only drive when the port asks and it is not the timer clock
      drive_q <= portDirBit && (sel_q != SEL_EXT);
    end
  end

  assign rdData = rdData_q;
  assign overflowIrq = irq_q;
  assign overflowTick = ovfTick_q;
  assign extPinDriveOk = drive_q;
  assign counterValue = count_q;
  assign chan0Ctrl = {chFlag_q[0], ch0_q[6:0]};
  assign chan1Ctrl = {chFlag_q[1], ch1_q[6:0]};

  sequence s_flag_read;
    clkEn && rdStatus && ovfFlag_q && !ovfEvent;
  endsequence

  sequence s_zero_write;
    clkEn && wrStatus && !wrData[BIT_FLAG] && !ovfEvent;
  endsequence

  property p_two_step_clear;
    @(posedge clk) disable iff (!nrst)
      s_flag_read ##1 s_zero_write |=> !ovfFlag_q;
  endproperty
  a_two_step_clear: assert property (p_two_step_clear) else $error("flag not cleared");

  property p_write_one_keeps;
    @(posedge clk) disable iff (!nrst)
      (clkEn && ovfFlag_q && wrStatus && wrData[BIT_FLAG]) |=> ovfFlag_q;
  endproperty
  a_write_one_keeps: assert property (p_write_one_keeps) else $error("flag lost on one-write");

  property p_event_beats_clear;
    @(posedge clk) disable iff (!nrst)
      (clkEn && ovfEvent) |=> ovfFlag_q;
  endproperty
  a_event_beats_clear: assert property (p_event_beats_clear) else $error("overflow lost");

  property p_wrap;
    @(posedge clk) disable iff (!nrst)
      (clkEn && running && tick && atModulo && !cntRstWr) |=> (count_q == CNT_RST);
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap at modulo");

  property p_advance;
    @(posedge clk) disable iff (!nrst)
      (clkEn && running && tick && !atModulo && !cntRstWr)
        |=> (count_q == $past(count_q) + 16'h0001);
  endproperty
  a_advance: assert property (p_advance) else $error("counter did not advance by one");

  property p_hold;
    @(posedge clk) disable iff (!nrst)
      (clkEn && (halt_q || breakActive || stopMode) && !cntRstWr) |=> $stable(count_q);
  endproperty
  a_hold: assert property (p_hold) else $error("counter moved while held");

  property p_cnt_reset;
    @(posedge clk) disable iff (!nrst)
      (clkEn && cntRstWr) |=> (count_q == CNT_RST && pre_q == PRE_RST && !latched_q);
  endproperty
  a_cnt_reset: assert property (p_cnt_reset) else $error("counter reset incomplete");

  property p_irq;
    @(posedge clk) disable iff (!nrst)
      (clkEn && ovfFlag_q && irqEn_q) |=> overflowIrq;
  endproperty
  a_irq: assert property (p_irq) else $error("overflow request missing");

  property p_mod_mute;
    @(posedge clk) disable iff (!nrst)
      (clkEn && modPending_q && !ovfFlag_q) |=> !ovfFlag_q;
  endproperty
  a_mod_mute: assert property (p_mod_mute) else $error("overflow flagged during modulo write");

  property p_latch;
    @(posedge clk) disable iff (!nrst)
      (clkEn && rdStb && addr == OFS_CNT_HI && !latched_q && !cntRstWr)
        |=> (latched_q && lowBuf_q == $past(count_q[DATA_W-1:0]));
  endproperty
  a_latch: assert property (p_latch) else $error("low byte not captured");

  property p_ext_input;
    @(posedge clk) disable iff (!nrst)
      (clkEn && sel_q == SEL_EXT) |=> !extPinDriveOk;
  endproperty
  a_ext_input: assert property (p_ext_input) else $error("clock pin allowed to drive");
endmodule : tmr_core

`default_nettype wire

// ==== shared/tmr_pkg.sv ====
// constants, offsets and field layout shared by the modulo timer core
// Notes on behaviour
// - clock select 0..6 picks bus clock /1../64, 7 picks external pin; reset clears.
// - with the external clock selected the pin is an input, whatever its direction bit.
// - each channel pin is capture or compare; only channel 0 offers buffered modes.
// - counter equal to modulo sets the overflow flag and restarts from zero.
// - overflow flag clears by reading status with flag set, then writing zero.
// - an overflow between that read and write cancels the clear; writing one does nothing.
// - overflow flag and enable both set raise the overflow request; reset clears enable.
// - halt bit freezes the counter; reset sets it, so counting waits for software.
// - write-only counter reset clears counter and prescaler, self-clears, reads zero.
// - halt and counter reset in one write leave the counter halted at zero.
// - counter reads as read-only high and low bytes; writes to them are ignored.
// - high byte read holds the low byte until the low byte is read.
// - system reset and counter reset clear both readout bytes.
// - modulo high write blocks overflow flagging until the modulo low byte is written.
// - modulo register is two read/write bytes, all ones after reset.
// - the counter holds while the break state lasts.
// - counter runs in wait and holds, without loss, in the stop state.
`default_nettype none

package tmr_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int CNT_W = 16;
  localparam int PRE_W = 7;
  localparam int SEL_W = 3;

  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_CNT_HI = 8'h22;
  localparam logic [ADDR_W-1:0] OFS_CNT_LO = 8'h23;
  localparam logic [ADDR_W-1:0] OFS_MOD_HI = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_MOD_LO = 8'h25;
  localparam logic [ADDR_W-1:0] OFS_CH0 = 8'h26;
  localparam logic [ADDR_W-1:0] OFS_CH1 = 8'h29;

  // status/control field positions
  localparam int BIT_FLAG = 7;
  localparam int BIT_IRQ_EN = 6;
  localparam int BIT_HALT = 5;
  localparam int BIT_CNT_RST = 4;
  localparam int BIT_SEL_LO = 0;
  // channel status/control field positions
  localparam int BIT_CH_FLAG = 7;
  localparam int BIT_CH_BUF = 5;

  localparam logic [SEL_W-1:0] SEL_RST = 3'h0;
  localparam logic [SEL_W-1:0] SEL_EXT = 3'h7;
  localparam logic HALT_RST = 1'b1;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [CNT_W-1:0] MOD_RST = 16'hFFFF;
  localparam logic [PRE_W-1:0] PRE_RST = 7'h00;
  localparam logic [DATA_W-1:0] CH_RST = 8'h00;
  localparam logic [DATA_W-1:0] RD_IDLE = 8'h00;
  // channel 1 has no buffered-mode bit
  localparam logic [DATA_W-1:0] CH1_WR_MASK = 8'hDF;

  // upper limit on the external clock rate, in MHz
  localparam int EXT_CLK_MAX_MHZ = 4;
endpackage : tmr_pkg

`default_nettype wire

// ==== core/tmr_ext_sync.sv ====
// three-stage synchroniser and rising-edge detector for the external clock pin
`default_nettype none

module tmr_ext_sync (
  input wire logic clk,
  input wire logic nrst,
  input wire logic clkEn,
  input wire logic pinIn,
  output logic riseTick
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;
  logic rise_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else if (clkEn) begin
      s1_q <= pinIn;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a level only counts once stages two and three agree
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      level_q <= 1'b0;
      rise_q <= 1'b0;
    end else if (clkEn) begin
      if (s2_q == s3_q) begin
        level_q <= s3_q;
      end
      rise_q <= (s2_q == s3_q) && s3_q && !level_q;
    end
  end

  assign riseTick = rise_q;

  property p_one_tick;
    @(posedge clk) disable iff (!nrst)
      (clkEn && rise_q) |=> !rise_q;
  endproperty
  a_one_tick: assert property (p_one_tick) else $error("external tick lasted two cycles");
endmodule : tmr_ext_sync

`default_nettype wire

// ==== verification/tmr_ext_clk_model.sv ====
// external timer clock source standing on the far side of the clock pin
`default_nettype none

module tmr_ext_clk_model #(
  parameter int HALF = 13 // 260 ns period keeps under 4 MHz and half the bus clock
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic run,
  output logic pin,
  output int edges
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt;

  // a burst ends only after a high phase is finished, so the pin parks low between bursts
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin <= 1'b0;
      cnt <= 0;
      edges <= 0;
    end else if (run || pin) begin
      if (cnt == HALF - 1) begin
        cnt <= 0;
        pin <= !pin;
        edges <= edges + int'(!pin);
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule // tmr_ext_clk_model

`default_nettype wire

// ==== verification/tmr_core_bench.sv ====
// self-checking bench for the modulo timer core
`default_nettype none

module tmr_core_bench;
  import tmr_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [7:0] RA [9] = '{8'h20, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h29, 8'h21, 8'h30};
  localparam logic [7:0] RE [9] = '{8'h20, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};

  logic clk, nrst, clkEn, wrStb, rdStb, extRun, extPin, portDirBit, breakActive, stopMode;
  logic driveOk, irq, tick;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wrData, rdData;
  logic [15:0] cntVal;
  int badCount, totalChecks, extEdges;

  tmr_core i_tmr_core (
    .clk(clk), .nrst(nrst), .clkEn(clkEn), .addr(addr), .wrData(wrData),
    .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .extClockPin(extPin),
    .portDirBit(portDirBit), .breakActive(breakActive), .stopMode(stopMode),
    .chanEvent(2'b00), .extPinDriveOk(driveOk), .overflowIrq(irq), .overflowTick(tick),
    .counterValue(cntVal), .chan0Ctrl(), .chan1Ctrl()
  );

  tmr_ext_clk_model i_tmr_ext_clk_model (
    .clk(clk), .nrst(nrst), .run(extRun), .pin(extPin), .edges(extEdges)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [15:0] expCount(int k, int sel);
    return 16'(k >> sel);
  endfunction

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string msg);
    totalChecks++;
    if (got !== exp) begin
      badCount++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrStb <= 1'b1;
    @(posedge clk);
    wrStb <= 1'b0;
  endtask

  // read data are sampled in the single cycle after the read edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge clk);
    rdStb <= 1'b0;
    #1;
    d = rdData;
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp, input string msg);
    logic [7:0] d;
    rd(a, d);
    check(16'(d), 16'(exp), msg);
  endtask

  task automatic cnt16(output logic [15:0] v);
    rd(OFS_CNT_HI, v[15:8]);
    rd(OFS_CNT_LO, v[7:0]);
  endtask

  task automatic waitTick(output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (tick !== 1'b1 && n < 200);
  endtask

  task automatic endTest(input string s);
    $display("test %s done", s);
  endtask

  task automatic finishTest();
    $display("checks %0d mismatches %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    badCount++;
    $display("[FAIL] %0t watchdog expired", $time);
    finishTest();
  end

  initial begin
    logic [7:0] d;
    logic [15:0] v;
    int n, k, m, mv;
    nrst = 1'b0;
    clkEn = 1'b1;
    addr = '0;
    wrData = '0;
    wrStb = 1'b0;
    rdStb = 1'b0;
    extRun = 1'b0;
    portDirBit = 1'b1;
    breakActive = 1'b0;
    stopMode = 1'b0;
    badCount = 0;
    totalChecks = 0;
    void'($urandom(93938));
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 9; i++) rdChk(RA[i], RE[i], "reset value");
    check(16'(irq), 16'h0000, "irq after reset");
    check(16'(driveOk), 16'h0001, "pin drive with bus clock");
    d = 8'($urandom);
    wr(OFS_CH0, d);
    rdChk(OFS_CH0, d & 8'h7F, "channel 0 byte");
    wr(OFS_CH1, d);
    rdChk(OFS_CH1, d & 8'h5F, "channel 1 byte");
    endTest("reset");

    for (int s = 0; s < 7; s++) begin
      m = 1 + $urandom_range(2);
      k = (s == 0) ? 2 + $urandom_range(20) : m * (1 << s) + (1 << (s - 1));
      wr(OFS_STATUS, 8'h30 | 8'(s));
      cnt16(v);
      check(v, 16'h0000, "halt with reset");
      wr(OFS_STATUS, 8'(s));
      repeat (k - 2) @(posedge clk);
      wr(OFS_STATUS, 8'h20 | 8'(s));
      cnt16(v);
      check(v, expCount(k, s), "prescaled count");
    end
    endTest("prescaler");

    wr(OFS_STATUS, 8'h30);
    wr(OFS_STATUS, 8'h00);
    repeat (6) @(posedge clk);
    breakActive <= 1'b1;
    repeat (5) @(posedge clk);
    breakActive <= 1'b0;
    stopMode <= 1'b1;
    repeat (4) @(posedge clk);
    stopMode <= 1'b0;
    repeat (5) @(posedge clk);
    wr(OFS_STATUS, 8'h20);
    cnt16(v);
    check(v, 16'd13, "count held in break and stop");
    rdChk(OFS_CNT_HI, 8'h00, "high byte");
    wr(OFS_CNT_HI, 8'hFF);
    wr(OFS_CNT_LO, 8'hFF);
    wr(OFS_STATUS, 8'h00);
    repeat (8) @(posedge clk);
    wr(OFS_STATUS, 8'h20);
    rdChk(OFS_CNT_LO, 8'd13, "latched low byte");
    cnt16(v);
    check(v, 16'd23, "live count after release");
    check(cntVal, 16'd23, "counter port while halted");
    endTest("hold and latch");

    wr(OFS_STATUS, 8'h37);
    repeat (2) @(posedge clk);
    check(16'(driveOk), 16'h0000, "pin drive with ext clock");
    wr(OFS_STATUS, 8'h07);
    extRun <= 1'b1;
    repeat (300) @(posedge clk);
    extRun <= 1'b0;
    repeat (60) @(posedge clk);
    wr(OFS_STATUS, 8'h27);
    cnt16(v);
    check(v, 16'(extEdges), "ext edge count");
    wr(OFS_STATUS, 8'h30);
    repeat (2) @(posedge clk);
    check(16'(driveOk), 16'h0001, "pin drive restored");
    endTest("external clock");

    mv = 4 + $urandom_range(8);
    wr(OFS_MOD_HI, 8'h00);
    wr(OFS_MOD_LO, 8'(mv));
    rdChk(OFS_MOD_LO, 8'(mv), "modulo low");
    wr(OFS_STATUS, 8'h40);
    waitTick(n);
    waitTick(n);
    check(16'(n), 16'(mv + 1), "overflow period");
    wr(OFS_STATUS, 8'hE0);
    check(16'(irq), 16'h0001, "irq raised");
    rdChk(OFS_STATUS, 8'hE0, "flag after write one");
    wr(OFS_STATUS, 8'h60);
    rdChk(OFS_STATUS, 8'h60, "flag cleared");
    check(16'(irq), 16'h0000, "irq dropped");
    wr(OFS_STATUS, 8'h40);
    waitTick(n);
    rd(OFS_STATUS, d);
    repeat (mv + 2) @(posedge clk);
    wr(OFS_STATUS, 8'h40);
    rdChk(OFS_STATUS, 8'hC0, "clear lost to new overflow");
    wr(OFS_STATUS, 8'h60);
    rd(OFS_STATUS, d);
    wr(OFS_STATUS, 8'h30);
    rdChk(OFS_STATUS, 8'h20, "flag cleared while halted");
    rdChk(OFS_MOD_LO, 8'(mv), "modulo kept by counter reset");
    wr(OFS_MOD_HI, 8'h00);
    wr(OFS_STATUS, 8'h00);
    n = 0;
    repeat (3 * mv + 9) begin
      @(posedge clk);
      #1;
      if (tick === 1'b1) n++;
    end
    check(16'(n), 16'h0000, "overflow while muted");
    wr(OFS_MOD_LO, 8'(mv));
    waitTick(n);
    check(16'(n < 40), 16'h0001, "overflow resumes");
    endTest("overflow");
    finishTest();
  end
endmodule // tmr_core_bench

`default_nettype wire
